// *** rtl/iome_pkg.sv ***
// Overview of operation
// - increment_file_op adds one to file register, writes dest, updates null flag.
// - increment_skip_on_null increments into dest, no flags, skips when result is zero.
// - taken skip discards prefetched instruction, runs a no-op; two cycles total.
// - jump_absolute loads 9-bit operand to pc<8:0>, condition bits <6:5> to pc<10:9>.
// - jump_absolute takes two cycles, flushing the prefetched instruction.
// - or_literal_op ORs accumulator with 8-bit literal into accumulator, updates null flag.
// - or_register_op ORs accumulator with file register into dest, updates null flag.
// - store_accumulator_op copies accumulator to file register, flags unchanged.
// - copy_register_op moves file register to dest and updates null flag.
package iome_pkg;
   localparam int DATA_W = 8;
   localparam int ADDR_W = 5;
   localparam int PC_W   = 11;
   localparam int JUMP_W = 9;
   localparam int INSN_W = 12;
   // condition register bits that supply the page of a jump
   localparam int PAGE_LO = 5;
   localparam int PAGE_HI = 6;
   localparam int DEST_BIT = 5;
   localparam logic [PC_W-1:0]   PC_RESET  = 11'h000;
   localparam logic [PC_W-1:0]   PC_STEP   = 11'h001;
   localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
   localparam logic [DATA_W-1:0] DATA_ONE  = 8'h01;
   // opcode patterns of the twelve-bit instruction word
   localparam logic [5:0] OPC_INC_FILE  = 6'h0a;
   localparam logic [5:0] OPC_INC_SKIP  = 6'h0f;
   localparam logic [5:0] OPC_OR_FILE   = 6'h04;
   localparam logic [5:0] OPC_COPY_FILE = 6'h08;
   localparam logic [6:0] OPC_STORE_ACC = 7'h01;
   localparam logic [3:0] OPC_OR_LIT    = 4'hd;
   localparam logic [2:0] OPC_JUMP      = 3'h5;

   typedef enum logic [7:0] {
      IOME_OP_NONE  = 8'h01,
      IOME_OP_INC   = 8'h02,
      IOME_OP_INCSZ = 8'h04,
      IOME_OP_JUMP  = 8'h08,
      IOME_OP_ORL   = 8'h10,
      IOME_OP_ORF   = 8'h20,
      IOME_OP_STW   = 8'h40,
      IOME_OP_COPY  = 8'h80
   } iome_op_type;

   typedef enum logic [1:0] {
      IOME_ST_EXEC  = 2'h1,
      IOME_ST_FLUSH = 2'h2
   } iome_state_type;
endpackage

// *** rtl/iome_decode.sv ***
`timescale 1ns/1ps
module iome_decode (
   // instruction word
   input  wire logic [iome_pkg::INSN_W-1:0] insn_i,
   // decoded operation
   output iome_pkg::iome_op_type            op_o
);
   import iome_pkg::*;

   always_comb begin
      op_o = IOME_OP_NONE;
      if (insn_i[11:6] == OPC_INC_FILE) begin
         op_o = IOME_OP_INC;
      end else if (insn_i[11:6] == OPC_INC_SKIP) begin
         op_o = IOME_OP_INCSZ;
      end else if (insn_i[11:6] == OPC_OR_FILE) begin
         op_o = IOME_OP_ORF;
      end else if (insn_i[11:6] == OPC_COPY_FILE) begin
         op_o = IOME_OP_COPY;
      end else if (insn_i[11:5] == OPC_STORE_ACC) begin
         op_o = IOME_OP_STW;
      end else if (insn_i[11:8] == OPC_OR_LIT) begin
         op_o = IOME_OP_ORL;
      end else if (insn_i[11:9] == OPC_JUMP) begin
         op_o = IOME_OP_JUMP;
      end
   end
endmodule // iome_decode

// *** rtl/iome_exec.sv ***
`timescale 1ns/1ps
module iome_exec (
   // clock, reset, enable
   input  wire logic                         clk_i,
   input  wire logic                         rst_i,
   input  wire logic                         ce_i,
   // prefetched instruction
   input  wire logic [iome_pkg::INSN_W-1:0]  insn_i,
   // file register read data for the addressed location
   input  wire logic [iome_pkg::DATA_W-1:0]  file_rdata_i,
   // condition register supplied by the rest of the core
   input  wire logic [iome_pkg::DATA_W-1:0]  cond_reg_i,
   // file register access
   output logic      [iome_pkg::ADDR_W-1:0]  file_addr_o,
   output logic                              file_we_o,
   output logic      [iome_pkg::DATA_W-1:0]  file_wdata_o,
   // core state
   output logic      [iome_pkg::DATA_W-1:0]  accum_o,
   output logic                              null_result_flag_o,
   output logic      [iome_pkg::PC_W-1:0]    program_counter_o,
   output logic                              flush_o
);
   import iome_pkg::*;

   typedef struct packed {
      iome_state_type          state;
      logic [DATA_W-1:0]       accum;
      logic                    nflag;
      logic [PC_W-1:0]         pc;
      logic                    we;
      logic [ADDR_W-1:0]       waddr;
      logic [DATA_W-1:0]       wdata;
   } iome_regs_type;

   iome_regs_type r;
   iome_regs_type next_r;
   iome_op_type   op;
   logic [DATA_W-1:0] result;
   logic              dest_file;

   iome_decode u_decode (
      .insn_i (insn_i),
      .op_o   (op)
   );

   assign dest_file = insn_i[DEST_BIT];

   // file address comes straight from the word; the register file reads it combinationally
   assign file_addr_o = insn_i[ADDR_W-1:0];

   always_comb begin
      next_r = r;
      next_r.we = 1'b0;
      result = DATA_ZERO;
      if (r.state == IOME_ST_FLUSH) begin
         // the prefetched word is dropped and executes as a no-op
         next_r.state = IOME_ST_EXEC;
         next_r.pc    = r.pc + PC_STEP;
      end else begin
         next_r.pc = r.pc + PC_STEP;
         case (op)
            IOME_OP_INC: begin
               result = file_rdata_i + DATA_ONE;
               next_r.nflag = (result == DATA_ZERO);
            end
            IOME_OP_INCSZ: begin
               result = file_rdata_i + DATA_ONE;
               if (result == DATA_ZERO) begin
                  next_r.state = IOME_ST_FLUSH;
               end
            end
            IOME_OP_ORL: begin
               result = r.accum | insn_i[DATA_W-1:0];
               next_r.nflag = (result == DATA_ZERO);
            end
            IOME_OP_ORF: begin
               result = r.accum | file_rdata_i;
               next_r.nflag = (result == DATA_ZERO);
            end
            IOME_OP_COPY: begin
               result = file_rdata_i;
               next_r.nflag = (result == DATA_ZERO);
            end
            IOME_OP_STW: begin
               result = r.accum;
            end
            IOME_OP_JUMP: begin
               next_r.pc = {cond_reg_i[PAGE_HI:PAGE_LO], insn_i[JUMP_W-1:0]};
               next_r.state = IOME_ST_FLUSH;
            end
            default: begin
            end
         endcase
         case (op)
            IOME_OP_INC, IOME_OP_INCSZ, IOME_OP_ORF, IOME_OP_COPY: begin
               if (dest_file) begin
                  next_r.we = 1'b1;
               end else begin
                  next_r.accum = result;
               end
            end
            IOME_OP_ORL: begin
               next_r.accum = result;
            end
            IOME_OP_STW: begin
               next_r.we = 1'b1;
            end
            default: begin
            end
         endcase
         next_r.waddr = insn_i[ADDR_W-1:0];
         next_r.wdata = result;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         r.state <= IOME_ST_EXEC;
         r.accum <= DATA_ZERO;
         r.nflag <= 1'b0;
         r.pc    <= PC_RESET;
         r.we    <= 1'b0;
         r.waddr <= '0;
         r.wdata <= DATA_ZERO;
      end else if (ce_i) begin
         r <= next_r;
      end
   end

   // write strobe is registered, one cycle after execute; gated by enable so a freeze
   // never repeats a write
   assign file_we_o          = r.we & ce_i;
   assign file_wdata_o       = r.wdata;
   assign accum_o            = r.accum;
   assign null_result_flag_o = r.nflag;
   assign program_counter_o  = r.pc;
   assign flush_o            = (r.state == IOME_ST_FLUSH);

   a_jump_target: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && r.state == IOME_ST_EXEC && op == IOME_OP_JUMP) |=>
      r.pc == {$past(cond_reg_i[PAGE_HI:PAGE_LO]), $past(insn_i[JUMP_W-1:0])})
      else $error("jump target wrong");

   sequence s_jump_taken;
      ce_i && r.state == IOME_ST_EXEC && op == IOME_OP_JUMP;
   endsequence
   a_jump_flush: assert property (@(posedge clk_i) disable iff (rst_i)
      s_jump_taken |=> flush_o)
      else $error("jump did not flush");

   a_skip_on_null: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && r.state == IOME_ST_EXEC && op == IOME_OP_INCSZ && file_rdata_i == 8'hff)
      |=> flush_o)
      else $error("skip not taken on zero");

   a_skip_flags: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && r.state == IOME_ST_EXEC && op == IOME_OP_INCSZ) |=> $stable(r.nflag))
      else $error("skip changed flag");

   a_flush_noop: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && flush_o) |=> (!flush_o && $stable(r.accum) && !r.we))
      else $error("flushed word had effect");

   a_inc_flag: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && r.state == IOME_ST_EXEC && op == IOME_OP_INC && !dest_file) |=>
      (r.accum == $past(file_rdata_i) + 8'h01) && (r.nflag == (r.accum == 8'h00)))
      else $error("increment wrong");

   a_orl_result: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && r.state == IOME_ST_EXEC && op == IOME_OP_ORL) |=>
      r.accum == ($past(r.accum) | $past(insn_i[7:0])) && r.nflag == (r.accum == 8'h00))
      else $error("or literal wrong");

   a_orf_dest: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && r.state == IOME_ST_EXEC && op == IOME_OP_ORF && dest_file) |=>
      r.we && r.wdata == ($past(r.accum) | $past(file_rdata_i)) && $stable(r.accum))
      else $error("or register wrong");

   a_store_acc: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && r.state == IOME_ST_EXEC && op == IOME_OP_STW) |=>
      r.we && r.wdata == $past(r.accum) && $stable(r.nflag))
      else $error("store accumulator wrong");

   a_copy_test: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && r.state == IOME_ST_EXEC && op == IOME_OP_COPY) |=>
      r.nflag == ($past(file_rdata_i) == DATA_ZERO))
      else $error("move flag wrong");

   a_copy_dest: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && r.state == IOME_ST_EXEC && op == IOME_OP_COPY && dest_file) |=>
      r.we && r.wdata == $past(file_rdata_i) && $stable(r.accum))
      else $error("move to file wrong");

   a_inc_dest: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && r.state == IOME_ST_EXEC && op == IOME_OP_INC && dest_file) |=>
      r.we && r.wdata == DATA_W'($past(file_rdata_i) + DATA_ONE) && $stable(r.accum))
      else $error("increment to file wrong");

   a_orf_acc: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && r.state == IOME_ST_EXEC && op == IOME_OP_ORF && !dest_file) |=>
      !r.we && r.accum == ($past(r.accum) | $past(file_rdata_i)))
      else $error("or register to accumulator wrong");

   a_flush_step: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && flush_o) |=> r.pc == $past(r.pc) + PC_STEP)
      else $error("flushed word did not advance pc");

   a_pc_step: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && r.state == IOME_ST_EXEC && op != IOME_OP_JUMP) |=>
      r.pc == $past(r.pc) + 11'h001)
      else $error("pc did not advance");
endmodule // iome_exec

// *** dv/test_iome_exec.sv ***
`timescale 1ns/1ps
module test_iome_exec;
   import iome_pkg::*;
   typedef struct packed {
      logic [DATA_W-1:0] acc;
      logic              z;
      logic [PC_W-1:0]   pc;
      logic              fl;
      logic              we;
      logic [DATA_W-1:0] wd;
      logic [ADDR_W-1:0] fa;
   } iome_note_type;
   logic              clk_i      = 1'b0;
   logic              rst_i      = 1'b1;
   logic              ce_i       = 1'b0;
   logic [INSN_W-1:0] insn_i     = 12'h000;
   logic [DATA_W-1:0] cond_reg_i = 8'h00;
   logic [DATA_W-1:0] file_rdata_i, file_wdata_o, accum_o, pd;
   logic [ADDR_W-1:0] file_addr_o, pa;
   logic              file_we_o, null_result_flag_o, flush_o, pend;
   logic [PC_W-1:0]   program_counter_o;
   logic [DATA_W-1:0] mem [0:31];
   iome_note_type     notes [$];
   iome_note_type     m, n;
   int                err_count = 0;
   int                cmp_count = 0;
   integer            seed      = 67;
   logic [31:0]       k;
   always #10 clk_i = ~clk_i;
   // the bench is the register file; written data lands after the edge, so no forwarding
   assign file_rdata_i = mem[file_addr_o];
   iome_exec i_iome_exec (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .insn_i(insn_i),
      .file_rdata_i(file_rdata_i), .cond_reg_i(cond_reg_i), .file_addr_o(file_addr_o),
      .file_we_o(file_we_o), .file_wdata_o(file_wdata_o), .accum_o(accum_o),
      .null_result_flag_o(null_result_flag_o), .program_counter_o(program_counter_o),
      .flush_o(flush_o));
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic step(input logic [INSN_W-1:0] ins,
                       input logic [DATA_W-1:0] cnd,
                       input logic              ce);
      logic [DATA_W-1:0] f, r;
      logic              d, wr;
      @(posedge clk_i);
      #2;
      if (pend) mem[pa] = pd;
      pend = 1'b0;
      insn_i = ins;
      cond_reg_i = cnd;
      ce_i = ce;
      f = mem[ins[4:0]];
      d = ins[DEST_BIT];
      wr = 1'b1;
      r = m.acc;
      m.we = 1'b0;
      m.fa = ins[ADDR_W-1:0];
      if (ce) begin
         m.pc = m.pc + PC_STEP;
         if (m.fl) begin
            m.fl = 1'b0;
         end else begin
            case (1'b1)
               ins[11:6] == OPC_INC_FILE: begin
                  r = f + DATA_ONE;
                  m.z = (r == DATA_ZERO);
               end
               ins[11:6] == OPC_INC_SKIP: begin
                  r = f + DATA_ONE;
                  m.fl = (r == DATA_ZERO);
               end
               ins[11:6] == OPC_OR_FILE: begin
                  r = m.acc | f;
                  m.z = (r == DATA_ZERO);
               end
               ins[11:6] == OPC_COPY_FILE: begin
                  r = f;
                  m.z = (r == DATA_ZERO);
               end
               ins[11:5] == OPC_STORE_ACC: begin
                  r = m.acc;
                  d = 1'b1;
               end
               ins[11:8] == OPC_OR_LIT: begin
                  r = m.acc | ins[7:0];
                  d = 1'b0;
                  m.z = (r == DATA_ZERO);
               end
               ins[11:9] == OPC_JUMP: begin
                  wr = 1'b0;
                  m.pc = {cnd[PAGE_HI:PAGE_LO], ins[8:0]};
                  m.fl = 1'b1;
               end
               default: wr = 1'b0;
            endcase
            if (wr && d) begin
               m.we = 1'b1;
               m.wd = r;
               pend = 1'b1;
               pa = ins[4:0];
               pd = r;
            end else if (wr) begin
               m.acc = r;
            end
         end
      end
      notes.push_back(m);
   endtask
   always @(posedge clk_i) begin
      #1;
      if (notes.size() > 0) begin
         n = notes.pop_front();
         check("accum", 16'(accum_o), 16'(n.acc));
         check("null flag", 16'(null_result_flag_o), 16'(n.z));
         check("program counter", 16'(program_counter_o), 16'(n.pc));
         check("flush", 16'(flush_o), 16'(n.fl));
         check("file write", 16'(file_we_o), 16'(n.we));
         check("file address", 16'(file_addr_o), 16'(n.fa));
         if (n.we) check("write data", 16'(file_wdata_o), 16'(n.wd));
      end
   end
   initial begin
      #20000;
      err_count++;
      final_report();
   end
   initial begin
      m = '0;
      pend = 1'b0;
      for (int i = 0; i < 32; i++) mem[i] = (i < 2) ? 8'hff : 8'($random(seed));
      repeat (3) @(posedge clk_i);
      #2;
      rst_i = 1'b0;
      check("reset state", {accum_o, 1'b0, null_result_flag_o, flush_o, file_we_o, 4'h0}, 16'h0);
      check("reset pc", 16'(program_counter_o), 16'h0);
      $display("test reset done");
      step({OPC_JUMP, 9'h123}, 8'h20, 1'b1);
      step({OPC_INC_FILE, 1'b1, 5'h00}, 8'h00, 1'b1);
      step({OPC_INC_FILE, 1'b1, 5'h00}, 8'h00, 1'b1);
      step({OPC_INC_SKIP, 1'b1, 5'h01}, 8'h00, 1'b1);
      step({OPC_STORE_ACC, 5'h02}, 8'h00, 1'b1);
      step({OPC_INC_SKIP, 1'b0, 5'h00}, 8'h00, 1'b1);
      step({OPC_OR_LIT, 8'h00}, 8'h00, 1'b0);
      step({OPC_COPY_FILE, 1'b1, 5'h01}, 8'h00, 1'b1);
      step({OPC_OR_LIT, 8'h00}, 8'h00, 1'b1);
      $display("test directed done");
      for (int i = 0; i < 300; i++) begin
         k = $random(seed);
         case (k[2:0])
            3'h0: step({OPC_INC_FILE, k[9:4]}, k[31:24], k[22:20] != 3'h0);
            3'h1: step({OPC_INC_SKIP, k[9:4]}, k[31:24], k[22:20] != 3'h0);
            3'h2: step({OPC_OR_FILE, k[9:4]}, k[31:24], k[22:20] != 3'h0);
            3'h3: step({OPC_COPY_FILE, k[9:4]}, k[31:24], k[22:20] != 3'h0);
            3'h4: step({OPC_STORE_ACC, k[8:4]}, k[31:24], k[22:20] != 3'h0);
            3'h5: step({OPC_OR_LIT, k[11:4]}, k[31:24], k[22:20] != 3'h0);
            3'h6: step({OPC_JUMP, k[12:4]}, k[31:24], k[22:20] != 3'h0);
            default: step(12'h000, k[31:24], k[22:20] != 3'h0);
         endcase
      end
      step(12'h000, 8'h00, 1'b0);
      @(posedge clk_i);
      #5;
      $display("test random done");
      final_report();
   end
endmodule // test_iome_exec
